// >>> common/ast_pkg.sv
// Purpose: constants for the asynchronous serial transceiver
// Assumes: 32-bit register port, 25 MHz clock
// Notes: offsets are byte addresses
package ast_pkg;
  localparam logic [5:0] OFF_DATA = 6'h00;
  localparam logic [5:0] OFF_CTRL = 6'h04;
  localparam logic [5:0] OFF_IEN = 6'h0C;
  localparam logic [5:0] OFF_STAT = 6'h10;
  localparam logic [5:0] OFF_DIV = 6'h24;
  localparam logic [5:0] OFF_TEST = 6'h28;
  localparam logic [14:0] CTRL_RST = 15'h0000;
  localparam logic [15:0] DIV_RST = 16'h0010;
  localparam logic [15:0] DIV_MIN = 16'h0010;
  localparam int C_ORDER = 2;
  localparam int C_TXEN = 4;
  localparam int C_RXEN = 5;
  localparam int C_LEN = 8;
  localparam int C_STOP2 = 10;
  localparam int C_PAR = 11;
  localparam int C_EVEN = 12;
  localparam int C_STICK = 13;
  localparam int C_BRK = 14;
  localparam logic [1:0] LEN_7 = 2'h0;
  localparam logic [1:0] LEN_9 = 2'h2;
  localparam logic [1:0] LEN_RSV = 2'h3;
  localparam int S_OVR = 1;
  localparam int S_PAR = 2;
  localparam int S_FRM = 3;
  localparam int S_BRK = 4;
  localparam int S_RDY = 5;
  localparam int S_THE = 7;
  localparam int S_DONE = 8;
  localparam logic [8:0] STAT_RST = 9'h180;
  localparam logic [6:0] IEN_MAP_RDY = 7'h01;
endpackage : ast_pkg

// >>> src/ast_sync.sv
// Purpose: three-flop synchroniser with agreement filter
// Assumes: input asynchronous to clk_i
// Notes: output changes once stages two and three agree
`timescale 1ns/10ps
module ast_sync
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // line
  input wire logic d_i,
  output logic q_o
);
  logic s1_q, s2_q, s3_q, q_q, q_d;
  always_comb
  begin
    q_d = q_q;
    if (s2_q == s3_q)
    begin
      q_d = s3_q;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      q_q <= 1'b1;
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= q_d;
    end
  end
  assign q_o = q_q;
endmodule : ast_sync

// >>> src/ast_uart.sv
// Purpose: async serial transceiver with register port
// Assumes: divisor at least 16, one clock domain
// Notes: no fifo; one holding register per direction
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module ast_uart
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [5:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // serial line and interrupt
  input wire logic rx_i,
  output logic tx_o,
  output logic irq_o
);
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } ast_state_t;

  ////////////////////////////////////////////////////////////////////
  logic rx_s;
  ast_sync u_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(rx_i),
    .q_o(rx_s)
  );

  logic [14:0] ctrl_q, ctrl_d;
  logic [6:0] ien_q, ien_d;
  logic [15:0] div_q, div_d;
  logic [1:0] test_q, test_d;
  logic [8:0] stat_q, stat_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [8:0] thr_q, thr_d;
  logic [8:0] rhr_q, rhr_d;
  logic wr_data, rd_data;
  logic [3:0] nbits;
  logic tx_par, par_on;

  assign wr_data = wr_i && addr_i == ast_pkg::OFF_DATA;
  assign rd_data = rd_i && addr_i == ast_pkg::OFF_DATA;
  assign par_on = ctrl_q[ast_pkg::C_PAR]
    && ctrl_q[ast_pkg::C_LEN +: 2] != ast_pkg::LEN_9;
  always_comb
  begin
    case (ctrl_q[ast_pkg::C_LEN +: 2])
      ast_pkg::LEN_7: nbits = 4'd7;
      ast_pkg::LEN_9: nbits = 4'd9;
      default: nbits = 4'd8;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // transmitter
  ast_state_t tst_q, tst_d;
  logic [15:0] tcnt_q, tcnt_d;
  logic [3:0] tbit_q, tbit_d;
  logic [8:0] tsh_q, tsh_d;
  logic tpar_q, tpar_d, tphase_q, tphase_d, tline_q, tline_d;
  logic tload, tfin;
  logic [8:0] tmask;
  assign tmask = (nbits == 4'd7) ? 9'h07F : (nbits == 4'd8) ? 9'h0FF
    : 9'h1FF;
  always_comb
  begin
    tst_d = tst_q;
    tcnt_d = tcnt_q;
    tbit_d = tbit_q;
    tsh_d = tsh_q;
    tpar_d = tpar_q;
    tphase_d = tphase_q;
    tline_d = tline_q;
    tload = 1'b0;
    tfin = 1'b0;
    tx_par = 1'b0;
    if (tst_q != ST_IDLE)
    begin
      tcnt_d = tcnt_q - 16'd1;
    end
    case (tst_q)
      ST_IDLE:
      begin
        tline_d = 1'b1;
        if (ctrl_q[ast_pkg::C_TXEN] && !stat_q[ast_pkg::S_THE])
        begin
          tload = 1'b1;
          tsh_d = thr_q & tmask;
          tpar_d = ^(thr_q & tmask);
          tst_d = ST_START;
          tcnt_d = div_q - 16'd1;
          tline_d = 1'b0;
          tbit_d = 4'd0;
          tphase_d = 1'b0;
        end
      end
      ST_START:
      begin
        if (tcnt_q == 16'd0)
        begin
          tst_d = ST_DATA;
          tcnt_d = div_q - 16'd1;
          tline_d = ctrl_q[ast_pkg::C_ORDER] ? tsh_q[nbits - 4'd1]
            : tsh_q[0];
        end
      end
      ST_DATA:
      begin
        if (tcnt_q == 16'd0)
        begin
          tcnt_d = div_q - 16'd1;
          tbit_d = tbit_q + 4'd1;
          tsh_d = ctrl_q[ast_pkg::C_ORDER] ? {tsh_q[7:0], 1'b0}
            : {1'b0, tsh_q[8:1]};
          if (tbit_q + 4'd1 < nbits)
          begin
            tline_d = ctrl_q[ast_pkg::C_ORDER] ? tsh_q[nbits - 4'd2]
              : tsh_q[1];
          end
          else if (par_on && tbit_q + 4'd1 == nbits)
          begin
            tx_par = tpar_q ^ ~ctrl_q[ast_pkg::C_EVEN];
            if (ctrl_q[ast_pkg::C_STICK])
            begin
              tx_par = ~ctrl_q[ast_pkg::C_EVEN];
            end
            tline_d = tx_par;
          end
          else
          begin
            tst_d = ST_STOP;
            tline_d = 1'b1;
          end
        end
      end
      ST_STOP:
      begin
        if (tcnt_q == 16'd0)
        begin
          tcnt_d = div_q - 16'd1;
          if (!tphase_q && ctrl_q[ast_pkg::C_STOP2] && nbits != 4'd7)
          begin
            tphase_d = 1'b1;
          end
          else
          begin
            tst_d = ST_IDLE;
            tfin = 1'b1;
          end
        end
      end
      default: tst_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tst_q <= ST_IDLE;
      tcnt_q <= 16'h0000;
      tbit_q <= 4'h0;
      tsh_q <= 9'h000;
      tpar_q <= 1'b0;
      tphase_q <= 1'b0;
      tline_q <= 1'b1;
    end
    else
    begin
      tst_q <= tst_d;
      tcnt_q <= tcnt_d;
      tbit_q <= tbit_d;
      tsh_q <= tsh_d;
      tpar_q <= tpar_d;
      tphase_q <= tphase_d;
      tline_q <= tline_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receiver
  ast_state_t rst_q, rst_d;
  logic [15:0] rcnt_q, rcnt_d, brk_q, brk_d;
  logic [3:0] rbit_q, rbit_d, brkb_q, brkb_d;
  logic [8:0] rsh_q, rsh_d;
  logic rpar_q, rpar_d, rprev_q, rdone, rperr, rferr, rbrk;
  logic [3:0] rlast, frame_bits;
  assign rlast = nbits + (par_on ? 4'd1 : 4'd0);
  assign frame_bits = rlast + 4'd2;
  always_comb
  begin
    rst_d = rst_q;
    rcnt_d = rcnt_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    rpar_d = rpar_q;
    rdone = 1'b0;
    rperr = 1'b0;
    rferr = 1'b0;
    if (rst_q != ST_IDLE)
    begin
      rcnt_d = rcnt_q - 16'd1;
    end
    case (rst_q)
      ST_IDLE:
      begin
        if (ctrl_q[ast_pkg::C_RXEN] && rprev_q && !rx_s)
        begin
          rst_d = ST_START;
          rcnt_d = {1'b0, div_q[15:1]};
        end
      end
      ST_START:
      begin
        if (rcnt_q == 16'd0)
        begin
          rst_d = rx_s ? ST_IDLE : ST_DATA;
          rcnt_d = div_q - 16'd1;
          rbit_d = 4'd0;
          rsh_d = 9'h000;
          rpar_d = 1'b0;
        end
      end
      ST_DATA:
      begin
        if (rcnt_q == 16'd0)
        begin
          rcnt_d = div_q - 16'd1;
          rbit_d = rbit_q + 4'd1;
          rpar_d = rpar_q ^ rx_s;
          if (rbit_q < nbits)
          begin
            if (ctrl_q[ast_pkg::C_ORDER])
            begin
              rsh_d = {rsh_q[7:0], rx_s};
            end
            else
            begin
              rsh_d[rbit_q] = rx_s;
            end
          end
          if (rbit_q + 4'd1 == rlast)
          begin
            rst_d = ST_STOP;
          end
        end
      end
      ST_STOP:
      begin
        if (rcnt_q == 16'd0)
        begin
          rst_d = ST_IDLE;
          rdone = 1'b1;
          rperr = par_on && (rpar_q ^ ~ctrl_q[ast_pkg::C_EVEN]);
          rferr = !rx_s;
        end
      end
      default: rst_d = ST_IDLE;
    endcase
    brk_d = brk_q;
    brkb_d = brkb_q;
    rbrk = 1'b0;
    if (rx_s)
    begin
      brk_d = 16'd0;
      brkb_d = 4'd0;
    end
    else if (brkb_q <= frame_bits)
    begin
      brk_d = brk_q + 16'd1;
      if (brk_q + 16'd1 == div_q)
      begin
        brk_d = 16'd0;
        brkb_d = brkb_q + 4'd1;
        rbrk = (brkb_q + 4'd1 == frame_bits);
      end
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rst_q <= ST_IDLE;
      rcnt_q <= 16'h0000;
      rbit_q <= 4'h0;
      rsh_q <= 9'h000;
      rpar_q <= 1'b0;
      rprev_q <= 1'b1;
      brk_q <= 16'h0000;
      brkb_q <= 4'h0;
    end
    else
    begin
      rst_q <= rst_d;
      rcnt_q <= rcnt_d;
      rbit_q <= rbit_d;
      rsh_q <= rsh_d;
      rpar_q <= rpar_d;
      rprev_q <= rx_s;
      brk_q <= brk_d;
      brkb_q <= brkb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers and flags
  always_comb
  begin
    ctrl_d = ctrl_q;
    ien_d = ien_q;
    div_d = div_q;
    test_d = test_q;
    thr_d = thr_q;
    rhr_d = rhr_q;
    stat_d = stat_q;
    rdata_d = 32'h00000000;
    if (wr_i)
    begin
      case (addr_i)
        ast_pkg::OFF_DATA: thr_d = wdata_i[8:0];
        ast_pkg::OFF_CTRL:
        begin
          ctrl_d = wdata_i[14:0] & 15'h7F34;
          // parity enable frozen in 9-bit mode
          if (ctrl_q[ast_pkg::C_LEN +: 2] == ast_pkg::LEN_9)
          begin
            ctrl_d[ast_pkg::C_PAR] = ctrl_q[ast_pkg::C_PAR];
          end
        end
        ast_pkg::OFF_IEN: ien_d = wdata_i[6:0];
        // divisor below 16 is software's fault
        ast_pkg::OFF_DIV: div_d = wdata_i[15:0];
        ast_pkg::OFF_TEST: test_d = wdata_i[1:0];
        ast_pkg::OFF_STAT: stat_d[4:1] = stat_q[4:1] & ~wdata_i[4:1];
        default: ;
      endcase
    end
    if (wr_data)
    begin
      stat_d[ast_pkg::S_THE] = 1'b0;
      stat_d[ast_pkg::S_DONE] = 1'b0;
    end
    if (rd_data)
    begin
      stat_d[ast_pkg::S_RDY] = 1'b0;
    end
    if (tload)
    begin
      stat_d[ast_pkg::S_THE] = 1'b1;
    end
    if (tfin && stat_q[ast_pkg::S_THE] && !wr_data)
    begin
      stat_d[ast_pkg::S_DONE] = 1'b1;
    end
    if (rdone)
    begin
      if (stat_q[ast_pkg::S_RDY] && !rd_data)
      begin
        stat_d[ast_pkg::S_OVR] = 1'b1;
      end
      else
      begin
        rhr_d = rsh_q;
        stat_d[ast_pkg::S_RDY] = 1'b1;
      end
      stat_d[ast_pkg::S_PAR] = stat_d[ast_pkg::S_PAR] | rperr;
      stat_d[ast_pkg::S_FRM] = stat_d[ast_pkg::S_FRM] | rferr;
    end
    if (rbrk)
    begin
      stat_d[ast_pkg::S_BRK] = 1'b1;
    end
    if (rd_i)
    begin
      case (addr_i)
        ast_pkg::OFF_DATA: rdata_d[8:0] = rhr_q;
        ast_pkg::OFF_CTRL: rdata_d[14:0] = ctrl_q;
        ast_pkg::OFF_IEN: rdata_d[6:0] = ien_q;
        ast_pkg::OFF_STAT: rdata_d[8:0] = stat_q;
        ast_pkg::OFF_DIV: rdata_d[15:0] = div_q;
        ast_pkg::OFF_TEST: rdata_d[1:0] = test_q;
        default: rdata_d = 32'h00000000;
      endcase
    end
    irq_d = |({stat_d[ast_pkg::S_BRK], stat_d[ast_pkg::S_FRM],
      stat_d[ast_pkg::S_PAR], stat_d[ast_pkg::S_OVR],
      stat_d[ast_pkg::S_DONE], stat_d[ast_pkg::S_THE],
      stat_d[ast_pkg::S_RDY]} & ien_d);
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= ast_pkg::CTRL_RST;
      ien_q <= 7'h00;
      div_q <= ast_pkg::DIV_RST;
      test_q <= 2'h0;
      thr_q <= 9'h000;
      rhr_q <= 9'h000;
      stat_q <= ast_pkg::STAT_RST;
      rdata_q <= 32'h00000000;
      irq_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ien_q <= ien_d;
      div_q <= div_d;
      test_q <= test_d;
      thr_q <= thr_d;
      rhr_q <= rhr_d;
      stat_q <= stat_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  logic tx_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_q <= 1'b1;
    end
    else
    begin
      tx_q <= tline_d && !ctrl_d[ast_pkg::C_BRK];
    end
  end
  assign tx_o = tx_q;
  assign rdata_o = rdata_q;
  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////
  // start bit follows load
  start_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tload && !ctrl_q[ast_pkg::C_BRK] |=> !tx_o)
    else $error("start bit not low");
  brk_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_q[ast_pkg::C_BRK] && $past(ctrl_q[ast_pkg::C_BRK]) |-> !tx_o)
    else $error("break not low");
  the_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_data && !tload |=> !stat_q[ast_pkg::S_THE])
    else $error("empty flag not cleared");
  rdy_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_data && !rdone |=> !stat_q[ast_pkg::S_RDY])
    else $error("ready not cleared");
  ovr_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rdone && stat_q[ast_pkg::S_RDY] && !rd_data
    |=> stat_q[ast_pkg::S_OVR] && $stable(rhr_q))
    else $error("overrun mishandled");
  rdy_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rdone && !stat_q[ast_pkg::S_RDY] |=> stat_q[ast_pkg::S_RDY])
    else $error("ready not set");
  the_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tload && !wr_data |=> stat_q[ast_pkg::S_THE])
    else $error("empty flag not set");
  rd_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_data |=> rdata_o == {23'h000000, $past(rhr_q)})
    else $error("data read upper bits");
endmodule : ast_uart

// >>> test/ast_remote.sv
// Purpose: remote serial transceiver facing the uart
// Assumes: bit time of BIT clocks, idle high line
// Notes: tasks are called from the bench
`timescale 1ns/10ps
module ast_remote #(
  parameter int BIT = 16
)
(
  // clock
  input wire logic clk_i,
  // serial lines
  input wire logic line_i,
  output logic line_o
);
  initial line_o = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // start low, stops high
  task automatic send(input logic [15:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      line_o <= f[i];
      repeat (BIT) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask : send
  // line held in spacing state
  task automatic hold_low(input int cyc);
    line_o <= 1'b0;
    repeat (cyc) @(posedge clk_i);
    line_o <= 1'b1;
  endtask : hold_low
  task automatic grab(input int n, output logic [15:0] f, output bit ok);
    int t;
    f = 16'h0000;
    ok = 1'b0;
    t = 0;
    while (line_i !== 1'b0 && t < 4000)
    begin
      @(posedge clk_i);
      t++;
    end
    if (t < 4000)
    begin
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < n; i++)
      begin
        f[i] = line_i;
        repeat (BIT) @(posedge clk_i);
      end
      ok = 1'b1;
    end
  endtask : grab
endmodule : ast_remote

// >>> test/async_serial_transceiver_tb_top.sv
// Purpose: self-checking bench for the serial transceiver
// Assumes: divisor left at 16, so one bit is 16 clocks
// Notes: frames are built by a model and compared bit by bit
`timescale 1ns/10ps
module async_serial_transceiver_tb_top;
  localparam int BIT = 16;
  logic clk_i;
  logic rst_i;
  logic [5:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  logic rx_i;
  logic tx_o;
  logic irq_o;
  int err_total;
  int samples_checked;
  int seed;
  logic [31:0] s;
  logic [15:0] f;
  logic [15:0] g;
  logic [14:0] c;
  bit ok;
  int n;
  logic [8:0] exp_q[$];
  logic [5:0] offs[7] = '{6'h00, 6'h04, 6'h0C, 6'h10, 6'h24, 6'h28, 6'h08};
  logic [31:0] rstv[7] = '{32'h0, 32'h0, 32'h0, 32'h180, 32'h10, 32'h0, 32'h0};

  ast_uart i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_i(rx_i), .tx_o(tx_o), .irq_o(irq_o));
  ast_remote #(.BIT(BIT)) i_far (.clk_i(clk_i), .line_i(tx_o),
    .line_o(rx_i));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic poll(input int b, output logic [31:0] d);
    int k;
    k = 0;
    d = 32'h0;
    while (d[b] !== 1'b1 && k < 300)
    begin
      rd(ast_pkg::OFF_STAT, d);
      k++;
    end
    if (k >= 300)
    begin
      $display("ERROR status bit %0d expected 1 seen 0", b);
      err_total++;
    end
  endtask : poll
  function automatic int frame(input logic [14:0] cf, input logic [8:0] d,
                               output logic [15:0] fr);
    int nb;
    int k;
    logic p;
    nb = 7 + int'(cf[9:8]);
    fr = 16'h0000;
    k = 1;
    p = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      fr[k] = cf[2] ? d[nb-1-i] : d[i];
      p = p ^ fr[k];
      k++;
    end
    if (cf[11] && nb != 9)
    begin
      fr[k] = cf[13] ? !cf[12] : (cf[12] ? p : !p);
      k++;
    end
    fr[k] = 1'b1;
    k++;
    if (cf[10] && nb > 7)
    begin
      fr[k] = 1'b1;
      k++;
    end
    return k;
  endfunction : frame
  // length from i, parity mode from i/3, stop count and order random
  function automatic logic [14:0] cfg(input int i);
    logic [14:0] r;
    int pm;
    pm = (i / 3) % 4;
    r = 15'h0030;
    r[9:8] = 2'(i % 3);
    r[11] = (pm != 0) && (i % 3 != 2);
    r[12] = (pm == 2) || (pm == 3 && i % 2 == 1);
    r[13] = (pm == 3);
    r[10] = $random(seed) & 1;
    r[2] = $random(seed) & 1;
    return r;
  endfunction : cfg
  task automatic rx_send(input logic [14:0] cf, input logic [8:0] d,
                         input int flip);
    logic [15:0] fr;
    int m;
    m = frame(cf, d, fr);
    if (flip >= 0)
      fr[flip] = ~fr[flip];
    exp_q.push_back(d & 9'((1 << (7 + int'(cf[9:8]))) - 1));
    i_far.send(fr, m);
  endtask : rx_send
  task automatic drain(input string nm);
    logic [31:0] d;
    rd(ast_pkg::OFF_DATA, d);
    chk(nm, {23'h0, exp_q.pop_front()}, d);
  endtask : drain
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk_i);
    $display("ERROR watchdog expected finish seen hang");
    err_total++;
    summarize();
  end
  initial
  begin
    rst_i = 1'b1;
    addr_i = 6'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    err_total = 0;
    samples_checked = 0;
    seed = 46893;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      rd(offs[i], s);
      chk("reset value", rstv[i], s);
    end
    chk("irq idle", 32'h0, {31'h0, irq_o});
    wr(ast_pkg::OFF_TEST, 32'h3);
    rd(ast_pkg::OFF_TEST, s);
    chk("test reg", 32'h3, s);
    wr(ast_pkg::OFF_TEST, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 12; i++)
    begin
      c = cfg(i);
      wr(ast_pkg::OFF_CTRL, 32'h130);
      wr(ast_pkg::OFF_CTRL, {17'h0, c});
      s = $random(seed);
      n = frame(c, s[8:0], g);
      wr(ast_pkg::OFF_DATA, {23'h0, s[8:0]});
      rd(ast_pkg::OFF_STAT, s);
      chk("done after write", 32'h0, {31'h0, s[8]});
      i_far.grab(n, f, ok);
      chk("tx frame", 32'h1, {31'h0, ok});
      chk("tx bits", {16'h0, g}, {16'h0, f});
      rd(ast_pkg::OFF_STAT, s);
      chk("tx flags", 32'h3, {30'h0, s[8:7]});
    end
    $display("transmit formats done");
    for (int i = 0; i < 9; i++)
    begin
      c = cfg(i);
      wr(ast_pkg::OFF_CTRL, 32'h130);
      wr(ast_pkg::OFF_CTRL, {17'h0, c});
      wr(ast_pkg::OFF_IEN, {31'h0, i > 4});
      s = $random(seed);
      rx_send(c, s[8:0], -1);
      poll(5, s);
      repeat (2) @(posedge clk_i);
      chk("irq ready", {31'h0, i > 4}, {31'h0, irq_o});
      drain("rx data");
      rd(ast_pkg::OFF_STAT, s);
      chk("rx status", 32'h0, {26'h0, s[5:1], 1'b0});
      chk("irq after read", 32'h0, {31'h0, irq_o});
    end
    wr(ast_pkg::OFF_IEN, 32'h0);
    $display("receive formats done");
    wr(ast_pkg::OFF_CTRL, 32'h130);
    wr(ast_pkg::OFF_CTRL, 32'h930);
    wr(ast_pkg::OFF_IEN, 32'h78);
    for (int e = 2; e < 4; e++)
    begin
      rx_send(15'h0930, 9'h0A5, e + 7);
      poll(e, s);
      chk("irq error", 32'h1, {31'h0, irq_o});
      repeat (BIT * 2) @(posedge clk_i);
      wr(ast_pkg::OFF_STAT, 32'h1 << e);
      exp_q.delete();
      rd(ast_pkg::OFF_DATA, s);
      rd(ast_pkg::OFF_STAT, s);
      chk("error clear", 32'h0, {26'h0, s[5:1], 1'b0});
      chk("irq clear", 32'h0, {31'h0, irq_o});
    end
    $display("receive errors done");
    rx_send(15'h0930, 9'h03C, -1);
    rx_send(15'h0930, 9'h0C3, -1);
    poll(1, s);
    drain("kept char");
    exp_q.delete();
    wr(ast_pkg::OFF_STAT, 32'h2);
    rd(ast_pkg::OFF_STAT, s);
    chk("overrun clear", 32'h0, {26'h0, s[5:1], 1'b0});
    i_far.hold_low(BIT * 30);
    poll(4, s);
    wr(ast_pkg::OFF_STAT, 32'h1E);
    rd(ast_pkg::OFF_DATA, s);
    rd(ast_pkg::OFF_STAT, s);
    chk("break clear", 32'h0, {26'h0, s[5:1], 1'b0});
    $display("overrun and break done");
    wr(ast_pkg::OFF_CTRL, 32'h4130);
    wr(ast_pkg::OFF_DATA, 32'h0FF);
    n = 0;
    repeat (BIT * 12)
    begin
      @(posedge clk_i);
      n += (tx_o !== 1'b0);
    end
    chk("break pin", 32'h0, n);
    rd(ast_pkg::OFF_STAT, s);
    chk("shifter ran", 32'h1, {31'h0, s[8]});
    wr(ast_pkg::OFF_CTRL, 32'h110);
    repeat (2) @(posedge clk_i);
    chk("break off", 32'h1, {31'h0, tx_o});
    rx_send(15'h0130, 9'h055, -1);
    repeat (BIT * 4) @(posedge clk_i);
    rd(ast_pkg::OFF_STAT, s);
    chk("rx off", 32'h0, {31'h0, s[5]});
    wr(ast_pkg::OFF_CTRL, 32'h120);
    wr(ast_pkg::OFF_DATA, 32'h055);
    i_far.grab(11, f, ok);
    chk("tx off", 32'h0, {31'h0, ok});
    $display("enables done");
    summarize();
  end
endmodule : async_serial_transceiver_tb_top
